// ==== rtl/epi_pkg.sv ====
// Package of constants and types for the external pin interrupt unit.
// Summary of operation
// - Pins raise requests even when driven as outputs
// - Group high request on enabled pins 23..16
// - Group mid request on enabled pins 14..8
// - Group low request on enabled pins 7..0
// - Per-pin masks gate each toggle group
// - Toggle activity seen without a running clock
// - Level mode requests while pin held low
// - Edges detected only while clock runs
// - Low level seen without clock for wake
// - Low level lost before start-up: no request
// - Pin request needs global flag and mask
// - Pins sampled; pulses over one clock caught
// - Pin b sense field at bits 3..2
// - Pin a sense field at bits 1..0
// - Sense register bits 7..4 read zero
// - Pin flag set on event, one clears
// - Group flag set on change, one clears
// - Group enable and global flag gate request
`default_nettype none

package epi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] EPI_IDX_SENSE    = 8'h69;
  localparam logic [7:0] EPI_IDX_PIN_MASK = 8'h3d;
  localparam logic [7:0] EPI_IDX_PIN_FLAG = 8'h3c;
  localparam logic [7:0] EPI_IDX_GRP_EN   = 8'h68;
  localparam logic [7:0] EPI_IDX_GRP_FLAG = 8'h3b;
  localparam logic [7:0] EPI_IDX_TMASK0   = 8'h6b;
  localparam logic [7:0] EPI_IDX_TMASK1   = 8'h6c;
  localparam logic [7:0] EPI_IDX_TMASK2   = 8'h6d;

  // Reset values
  localparam logic [3:0]  EPI_RST_SENSE = 4'h0;
  localparam logic [1:0]  EPI_RST_PMASK = 2'h0;
  localparam logic [2:0]  EPI_RST_GEN   = 3'h0;
  localparam logic [23:0] EPI_RST_TMASK = 24'h000000;

  // Field positions
  localparam int unsigned EPI_SENSE_A_LSB = 0;
  localparam int unsigned EPI_SENSE_B_LSB = 2;
  localparam logic [23:0] EPI_TMASK_IMPL  = 24'hff7fff;

  // Request vector positions
  localparam int unsigned EPI_RQ_PIN_A = 0;
  localparam int unsigned EPI_RQ_PIN_B = 1;
  localparam int unsigned EPI_RQ_LOW   = 2;
  localparam int unsigned EPI_RQ_MID   = 3;
  localparam int unsigned EPI_RQ_HIGH  = 4;

  localparam logic [1:0] EPI_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0]
  {
    EPI_SENSE_LOW  = 2'b00,
    EPI_SENSE_ANY  = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_t;

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic prev;
    logic hit;
  } epi_sense_state_t;

  typedef struct packed
  {
    logic [3:0]  sense;
    logic [1:0]  pin_mask;
    logic [1:0]  pin_flag;
    logic [2:0]  grp_en;
    logic [2:0]  grp_flag;
    logic [23:0] tmask;
    logic [23:0] tsync1;
    logic [23:0] tsync2;
    logic [23:0] tprev;
    logic        dp_write;
    logic        dp_ok;
    logic [7:0]  dp_idx;
    logic [31:0] rdata;
  } epi_state_t;

  function automatic logic epi_hit(input logic [31:0] addr,
                                   input logic [7:0]  idx);
    epi_hit = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0)
              && (addr[9:2] == idx);
  endfunction : epi_hit

endpackage : epi_pkg

`default_nettype wire

// ==== rtl/epi_sense_unit.sv ====
// Synchroniser and edge/level sense detector for one dedicated pin.
`default_nettype none

module epi_sense_unit
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       pin,
  input  wire logic [1:0] sense,
  output logic            pin_level,
  output logic            edge_hit
);

  epi_pkg::epi_sense_state_t st_reg;
  epi_pkg::epi_sense_state_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.s1   = pin;
    st_next.s2   = st_reg.s1;
    st_next.prev = st_reg.s2;
    // Edges exist only while mclk runs; no clock, no detection
    unique case (epi_pkg::epi_sense_t'(sense))
      epi_pkg::EPI_SENSE_LOW:
        st_next.hit = 1'b0;
      epi_pkg::EPI_SENSE_ANY:
        st_next.hit = st_reg.s2 ^ st_reg.prev;
      epi_pkg::EPI_SENSE_FALL:
        st_next.hit = st_reg.prev & ~st_reg.s2;
      epi_pkg::EPI_SENSE_RISE:
        st_next.hit = ~st_reg.prev & st_reg.s2;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, hit: 1'b0};
    else
      st_reg <= st_next;
  end

  assign pin_level = st_reg.s2;
  assign edge_hit  = st_reg.hit;

  property p_fall_hit;
    @(posedge mclk) disable iff (!rst_n)
    (sense == 2'b10 && st_reg.prev && !st_reg.s2) |=> edge_hit;
  endproperty
  a_fall_hit: assert property (p_fall_hit)
    else $error("falling edge missed");

  property p_rise_pulse;
    @(posedge mclk) disable iff (!rst_n)
    $rose(edge_hit) && sense == 2'b11 |=> !edge_hit;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse)
    else $error("rising hit longer than one cycle");

endmodule : epi_sense_unit

`default_nettype wire

// ==== rtl/epi_top.sv ====
// External pin interrupt unit with AHB-Lite register slave.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`default_nettype none

module epi_top
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_request_pin_a,
  input  wire logic        ext_request_pin_b,
  input  wire logic [23:0] toggle_watch_inputs,
  input  wire logic        global_int_enable,
  input  wire logic [4:0]  irq_ack,
  output logic [4:0]       irq_req,
  output logic             wake_async
);

  epi_pkg::epi_state_t st_reg;
  epi_pkg::epi_state_t st_next;

  logic [1:0]  pin_level;
  logic [1:0]  edge_hit;
  logic [1:0]  pins;
  logic [1:0]  level_mode;
  logic [23:0] tchg;
  logic [2:0]  grp_hit;
  logic [23:0] raw_chg;
  logic [2:0]  raw_grp;
  logic        accept;

  assign pins = {ext_request_pin_b, ext_request_pin_a};

  // Pins are watched whether driven by the board or by our own outputs
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sense
      epi_sense_unit u_sense
      (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pin       (pins[g]),
        .sense     (st_reg.sense[2*g+1:2*g]),
        .pin_level (pin_level[g]),
        .edge_hit  (edge_hit[g])
      );
      assign level_mode[g] =
        (st_reg.sense[2*g+1:2*g] == epi_pkg::EPI_SENSE_LOW);
    end
  endgenerate

  assign accept = hsel && hready && (htrans == epi_pkg::EPI_HTRANS_NONSEQ);

  // Synchronised change against previous sample, masked per pin
  assign tchg = (st_reg.tsync2 ^ st_reg.tprev) & st_reg.tmask;

  assign grp_hit[0] = |tchg[7:0];
  assign grp_hit[1] = |tchg[14:8];
  assign grp_hit[2] = |tchg[23:16];

  // Clockless compare for wake; glitches while the sync chain catches up
  assign raw_chg = (toggle_watch_inputs ^ st_reg.tprev) & st_reg.tmask;
  assign raw_grp[0] = |raw_chg[7:0];
  assign raw_grp[1] = |raw_chg[14:8];
  assign raw_grp[2] = |raw_chg[23:16];

  always_comb
  begin
    logic [1:0] pclr;
    logic [2:0] gclr;
    logic [7:0] wd;
    pclr = 2'h0;
    gclr = 3'h0;
    wd   = hwdata[7:0];
    st_next = st_reg;

    st_next.tsync1 = toggle_watch_inputs;
    st_next.tsync2 = st_reg.tsync1;
    st_next.tprev  = st_reg.tsync2;

    // Data phase of a write
    if (st_reg.dp_write && st_reg.dp_ok)
    begin
      unique case (st_reg.dp_idx)
        epi_pkg::EPI_IDX_SENSE:
          st_next.sense = wd[3:0];
        epi_pkg::EPI_IDX_PIN_MASK:
          st_next.pin_mask = wd[1:0];
        epi_pkg::EPI_IDX_PIN_FLAG:
          pclr = wd[1:0];
        epi_pkg::EPI_IDX_GRP_EN:
          st_next.grp_en = wd[2:0];
        epi_pkg::EPI_IDX_GRP_FLAG:
          gclr = wd[2:0];
        epi_pkg::EPI_IDX_TMASK0:
          st_next.tmask[7:0] = wd;
        epi_pkg::EPI_IDX_TMASK1:
          st_next.tmask[15:8] = wd & epi_pkg::EPI_TMASK_IMPL[15:8];
        epi_pkg::EPI_IDX_TMASK2:
          st_next.tmask[23:16] = wd;
        default:
          st_next.tmask = st_reg.tmask;
      endcase
    end

    // Handler entry or write-one clears; a new event wins over the clear
    pclr = pclr | irq_ack[1:0];
    gclr = gclr | irq_ack[4:2];
    st_next.pin_flag = (st_reg.pin_flag & ~pclr) | edge_hit;
    st_next.grp_flag = (st_reg.grp_flag & ~gclr) | grp_hit;

    // Level mode keeps the pin flag cleared
    if (st_next.sense[1:0] == epi_pkg::EPI_SENSE_LOW)
      st_next.pin_flag[0] = 1'b0;
    if (st_next.sense[3:2] == epi_pkg::EPI_SENSE_LOW)
      st_next.pin_flag[1] = 1'b0;

    // Address phase capture
    st_next.dp_write = accept && hwrite;
    st_next.dp_ok    = 1'b0;
    st_next.dp_idx   = haddr[9:2];
    st_next.rdata    = st_reg.rdata;
    if (accept)
    begin
      st_next.dp_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    end

    // Read data taken from the next state so a write just ahead is seen
    if (accept && !hwrite)
    begin
      st_next.rdata = 32'h00000000;
      if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_SENSE))
        st_next.rdata[3:0] = st_next.sense;
      else if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_PIN_MASK))
        st_next.rdata[1:0] = st_next.pin_mask;
      else if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_PIN_FLAG))
        st_next.rdata[1:0] = st_next.pin_flag;
      else if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_GRP_EN))
        st_next.rdata[2:0] = st_next.grp_en;
      else if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_GRP_FLAG))
        st_next.rdata[2:0] = st_next.grp_flag;
      else if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_TMASK0))
        st_next.rdata[7:0] = st_next.tmask[7:0];
      else if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_TMASK1))
        st_next.rdata[7:0] = st_next.tmask[15:8];
      else if (epi_pkg::epi_hit(haddr, epi_pkg::EPI_IDX_TMASK2))
        st_next.rdata[7:0] = st_next.tmask[23:16];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg          <= '0;
      st_reg.sense    <= epi_pkg::EPI_RST_SENSE;
      st_reg.pin_mask <= epi_pkg::EPI_RST_PMASK;
      st_reg.grp_en   <= epi_pkg::EPI_RST_GEN;
      st_reg.tmask    <= epi_pkg::EPI_RST_TMASK;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;

  // Level request follows the synchronised pin; a level gone early asks
  // nothing, so the driver must hold it through start-up
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (level_mode[i])
        irq_req[i] = global_int_enable && st_reg.pin_mask[i]
                     && !pin_level[i];
      else
        irq_req[i] = global_int_enable && st_reg.pin_mask[i]
                     && st_reg.pin_flag[i];
    end
    irq_req[4:2] = global_int_enable ? (st_reg.grp_flag & st_reg.grp_en)
                                     : 3'h0;
  end

  // Clockless wake: raw low level and raw toggles, no mclk needed
  assign wake_async =
      (level_mode[0] && st_reg.pin_mask[0] && !ext_request_pin_a)
    | (level_mode[1] && st_reg.pin_mask[1] && !ext_request_pin_b)
    | (|(raw_grp & st_reg.grp_en));

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_grp_low;
    grp_hit[0] |=> st_reg.grp_flag[0];
  endproperty
  a_grp_low: assert property (p_grp_low)
    else $error("group low flag not set");

  property p_grp_mid;
    (|((st_reg.tsync2[14:8] ^ st_reg.tprev[14:8]) & st_reg.tmask[14:8]))
    |=> st_reg.grp_flag[1];
  endproperty
  a_grp_mid: assert property (p_grp_mid)
    else $error("group mid flag not set");

  property p_grp_high;
    (|((st_reg.tsync2[23:16] ^ st_reg.tprev[23:16]) & st_reg.tmask[23:16]))
    ##0 st_reg.grp_en[2] ##0 global_int_enable
    |=> irq_req[epi_pkg::EPI_RQ_HIGH];
  endproperty
  a_grp_high: assert property (p_grp_high)
    else $error("group high request not raised");

  property p_mask_blocks;
    (st_reg.tmask[7:0] == 8'h00 && !st_reg.grp_flag[0]
     && !(st_reg.dp_write && st_reg.dp_idx == epi_pkg::EPI_IDX_TMASK0))
    |=> !st_reg.grp_flag[0];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked toggle set a flag");

  property p_level_req;
    (st_reg.sense[1:0] == 2'b00 && st_reg.pin_mask[0]
     && global_int_enable && !pin_level[0]) |-> irq_req[0];
  endproperty
  a_level_req: assert property (p_level_req)
    else $error("level request missing");

  property p_req_gated;
    irq_req[epi_pkg::EPI_RQ_PIN_B] |-> global_int_enable && st_reg.pin_mask[1];
  endproperty
  a_req_gated: assert property (p_req_gated)
    else $error("pin request without enables");

  property p_level_flag;
    (st_reg.sense[3:2] == 2'b00) |-> !st_reg.pin_flag[1];
  endproperty
  a_level_flag: assert property (p_level_flag)
    else $error("pin flag set in level mode");

  property p_sense_rsvd;
    (accept && !hwrite && haddr[9:2] == epi_pkg::EPI_IDX_SENSE)
    |=> hrdata[31:4] == 28'h0000000;
  endproperty
  a_sense_rsvd: assert property (p_sense_rsvd)
    else $error("reserved sense bits not zero");

  property p_grp_ack;
    (irq_ack[2] && !grp_hit[0]) |=> !st_reg.grp_flag[0];
  endproperty
  a_grp_ack: assert property (p_grp_ack)
    else $error("group flag not cleared by ack");

  property p_wake_level;
    (st_reg.sense[1:0] == 2'b00 && st_reg.pin_mask[0] && !ext_request_pin_a)
    |-> wake_async;
  endproperty
  a_wake_level: assert property (p_wake_level)
    else $error("level wake missing");

  property p_req_gated_a;
    irq_req[epi_pkg::EPI_RQ_PIN_A]
    |-> global_int_enable && st_reg.pin_mask[0];
  endproperty
  a_req_gated_a: assert property (p_req_gated_a)
    else $error("pin a request without enables");

  property p_level_flag_a;
    (st_reg.sense[1:0] == 2'b00) |-> !st_reg.pin_flag[0];
  endproperty
  a_level_flag_a: assert property (p_level_flag_a)
    else $error("pin a flag set in level mode");

  property p_pin_set;
    edge_hit[0]
    |=> st_reg.pin_flag[0] || (st_reg.sense[1:0] == 2'b00);
  endproperty
  a_pin_set: assert property (p_pin_set)
    else $error("pin a flag not set by event");

  property p_pin_ack;
    (irq_ack[0] && !edge_hit[0]) |=> !st_reg.pin_flag[0];
  endproperty
  a_pin_ack: assert property (p_pin_ack)
    else $error("pin a flag not cleared by ack");

  property p_grp_mid_ack;
    (irq_ack[3] && !grp_hit[1]) |=> !st_reg.grp_flag[1];
  endproperty
  a_grp_mid_ack: assert property (p_grp_mid_ack)
    else $error("group mid flag not cleared by ack");

  property p_grp_high_ack;
    (irq_ack[4] && !grp_hit[2]) |=> !st_reg.grp_flag[2];
  endproperty
  a_grp_high_ack: assert property (p_grp_high_ack)
    else $error("group high flag not cleared by ack");

  // A group request needs the global flag and its own enable
  property p_grp_gated;
    (irq_req[4:2] != 3'h0)
    |-> global_int_enable && ((irq_req[4:2] & ~st_reg.grp_en) == 3'h0);
  endproperty
  a_grp_gated: assert property (p_grp_gated)
    else $error("group request without enables");

  // Pin 15 has no mask bit, so it must never join group mid
  property p_tmask_hole;
    !st_reg.tmask[15];
  endproperty
  a_tmask_hole: assert property (p_tmask_hole)
    else $error("mask bit for missing pin set");

  property p_level_req_b;
    (st_reg.sense[3:2] == 2'b00 && st_reg.pin_mask[1]
     && global_int_enable && !pin_level[1]) |-> irq_req[1];
  endproperty
  a_level_req_b: assert property (p_level_req_b)
    else $error("pin b level request missing");

  property p_wake_level_b;
    (st_reg.sense[3:2] == 2'b00 && st_reg.pin_mask[1] && !ext_request_pin_b)
    |-> wake_async;
  endproperty
  a_wake_level_b: assert property (p_wake_level_b)
    else $error("pin b level wake missing");

  c_grp_high: cover property (st_reg.grp_flag[2] && irq_req[4]);
  c_pin_a_edge: cover property (edge_hit[0] ##1 irq_req[0]);
  c_level_b: cover property (level_mode[1] && irq_req[1]);
  c_set_on_clear: cover property (grp_hit[0] && irq_ack[2]);
  c_grp_ack: cover property (irq_ack[3] && st_reg.grp_flag[1]);

endmodule : epi_top

`default_nettype wire

// ==== tb/epi_pins.sv ====
// Board model driving the dedicated and toggle pins.
`default_nettype none

module epi_pins
(
  input  wire logic        mclk,
  input  wire logic        a_want,
  input  wire logic        b_want,
  input  wire logic [23:0] t_want,
  output logic             pin_a,
  output logic             pin_b,
  output logic [23:0]      pin_t
);
  timeunit 1ns;
  timeprecision 1ns;

  // Levels move only at an edge and are held for several cycles,
  // so pulses outlast a period and lows outlast any instruction
  always_ff @(posedge mclk)
  begin
    pin_a <= a_want;
    pin_b <= b_want;
    pin_t <= t_want;
  end
endmodule : epi_pins

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the external pin interrupt unit.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        a_want = 1'b1;
  logic        b_want = 1'b1;
  logic [23:0] t_want = 24'h0;
  logic        pin_a;
  logic        pin_b;
  logic [23:0] pin_t;
  logic        gie = 1'b0;
  logic [4:0]  irq_ack = 5'h0;
  logic [4:0]  irq_req;
  logic        wake_async;
  logic [31:0] rd;
  int          err_total = 0;
  int          checks_done = 0;
  int          seed;
  localparam logic [7:0] IDX [0:8] = '{epi_pkg::EPI_IDX_SENSE,
    epi_pkg::EPI_IDX_PIN_MASK, epi_pkg::EPI_IDX_PIN_FLAG,
    epi_pkg::EPI_IDX_GRP_EN, epi_pkg::EPI_IDX_GRP_FLAG,
    epi_pkg::EPI_IDX_TMASK0, epi_pkg::EPI_IDX_TMASK1,
    epi_pkg::EPI_IDX_TMASK2, 8'h70};

  assign hready = hreadyout;

  always #50 mclk = ~mclk;

  epi_pins u_pins
  (
    .mclk   (mclk),
    .a_want (a_want),
    .b_want (b_want),
    .t_want (t_want),
    .pin_a  (pin_a),
    .pin_b  (pin_b),
    .pin_t  (pin_t)
  );

  epi_top u_dut
  (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .hrdata              (hrdata),
    .ext_request_pin_a   (pin_a),
    .ext_request_pin_b   (pin_b),
    .toggle_watch_inputs (pin_t),
    .global_int_enable   (gie),
    .irq_ack             (irq_ack),
    .irq_req             (irq_req),
    .wake_async          (wake_async)
  );

  task end_of_test;
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] got,
           input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task ack(input logic [4:0] m);
    irq_ack <= m;
    tick(1);
    irq_ack <= 5'h0;
  endtask : ack

  // Bounded wait for hready sampled high at an edge
  task wait_rdy;
    @(posedge mclk);
    for (int k = 0; k < 50 && hready !== 1'b1; k++)
      @(posedge mclk);
    if (hready !== 1'b1)
    begin
      err_total++;
      end_of_test();
    end
  endtask : wait_rdy

  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= epi_pkg::EPI_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(nm, rd, e);
    chk("hresp", hresp, 1'b0);
  endtask : rdc

  function automatic logic ev(input logic [1:0] m, input logic rise);
    ev = (m == epi_pkg::EPI_SENSE_ANY)
         || (m == epi_pkg::EPI_SENSE_RISE && rise)
         || (m == epi_pkg::EPI_SENSE_FALL && !rise);
  endfunction : ev

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    logic       e;
    logic [1:0] g;
    logic [7:0] msk;
    logic [7:0] en;
    int         idx;
    seed = 64;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    hsel <= 1'b1;
    for (int i = 0; i < 9; i++)
      rdc("reset value", IDX[i], 32'h0);
    wr(epi_pkg::EPI_IDX_SENSE, 32'hff);
    rdc("sense", epi_pkg::EPI_IDX_SENSE, 32'h0f);
    wr(8'h70, 32'hff);
    rdc("unmapped", 8'h70, 32'h0);
    wr(epi_pkg::EPI_IDX_TMASK1, 32'hff);
    rdc("tmask1", epi_pkg::EPI_IDX_TMASK1, 32'h7f);
    gie <= 1'b1;
    wr(epi_pkg::EPI_IDX_PIN_MASK, 32'h3);
    // Each edge mode (any, fall, rise) sees a fall then a rise on each pin
    for (int p = 0; p < 2; p++)
      for (int m = 1; m < 4; m++)
        for (int r = 0; r < 2; r++)
        begin
          wr(epi_pkg::EPI_IDX_SENSE, 32'(m) << (2 * p));
          wr(epi_pkg::EPI_IDX_PIN_FLAG, 32'h3);
          if (p == 0)
            a_want <= r[0];
          else
            b_want <= r[0];
          tick(8);
          e = ev(m[1:0], r[0]);
          rdc("pin flag", epi_pkg::EPI_IDX_PIN_FLAG, 32'(e) << p);
          chk("pin req", irq_req[p], e);
          if (r == 1)
            ack(5'(1 << p));
          else
            wr(epi_pkg::EPI_IDX_PIN_FLAG, 32'(1 << p));
          tick(1);
          chk("pin cleared", irq_req[p], 1'b0);
        end
    wr(epi_pkg::EPI_IDX_SENSE, 32'h0);
    a_want <= 1'b0;
    b_want <= 1'b0;
    tick(4);
    chk("level req", irq_req[0], 1'b1);
    chk("level req b", irq_req[1], 1'b1);
    chk("level wake", wake_async, 1'b1);
    rdc("level flag", epi_pkg::EPI_IDX_PIN_FLAG, 32'h0);
    gie <= 1'b0;
    tick(2);
    chk("global off", irq_req[0], 1'b0);
    gie <= 1'b1;
    wr(epi_pkg::EPI_IDX_PIN_MASK, 32'h2);
    tick(1);
    chk("mask off", irq_req[0], 1'b0);
    a_want <= 1'b1;
    b_want <= 1'b1;
    // Random toggles; early passes hit every mask bit and pin 15
    for (int i = 0; i < 15; i++)
    begin
      g = 2'(i % 3);
      idx = g * 8 + ($random(seed) & 7);
      if (i == 1)
        idx = 15;
      msk = (i < 3) ? 8'hff : 8'($random(seed));
      en = 8'($random(seed));
      wr(epi_pkg::EPI_IDX_GRP_EN, {29'h0, en[2:0]});
      wr(epi_pkg::EPI_IDX_TMASK0 + {6'h0, g}, {24'h0, msk});
      wr(epi_pkg::EPI_IDX_GRP_FLAG, 32'h7);
      t_want[idx] <= ~t_want[idx];
      e = msk[idx % 8] && idx != 15;
      // Raw compare shows the toggle before the sync chain does
      tick(2);
      chk("toggle wake", wake_async, e & en[g]);
      tick(6);
      rdc("group flag", epi_pkg::EPI_IDX_GRP_FLAG, 32'(e) << g);
      chk("group req", irq_req[epi_pkg::EPI_RQ_LOW + g], e & en[g]);
      if (i % 2)
        wr(epi_pkg::EPI_IDX_GRP_FLAG, 32'h7);
      else
        ack(5'(4 << g));
      tick(1);
      chk("group clear", irq_req[epi_pkg::EPI_RQ_LOW + g], 1'b0);
    end
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
